/* File: pkg/fsp_pkg.sv */
// Constants, encodings and timing for the flash status and partition host.
// Assumes one 200 MHz clock and an external flash whose bus pins settle within a cycle.
package fsp_pkg;

  // ==========================================================================
  // Widths and timing
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int CLK_MHZ = 200;
  localparam int T_SETUP_NS = 20;
  localparam int T_STROBE_NS = 80;
  localparam int T_RECOVER_NS = 40;
  localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] STROBE_CYC = 8'((T_STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] RECOVER_CYC = 8'((T_RECOVER_NS * CLK_MHZ + 999) / 1000);
  localparam int POLL_LIMIT_DEFAULT = 32'h0010_0000;
  localparam logic [7:0] BUF_RETRY_LIMIT = 8'h10;

  // ==========================================================================
  // Flash commands, fields and defaults
  localparam logic [15:0] CMD_GROUP_SETUP = 16'h0060;
  localparam logic [15:0] CMD_GROUP_CONFIRM = 16'h0004;
  localparam logic [15:0] CMD_BUF_PROGRAM = 16'h00E8;
  localparam int SR_READY_BIT = 7;
  localparam int SR_ERASE_FAIL_BIT = 5;
  localparam int SR_PROG_FAIL_BIT = 4;
  localparam int XSR_ACCEPT_BIT = 7;
  localparam logic [15:0] SR_VALID_MASK = 16'h00FE;
  localparam int GROUP_LSB = 8;
  localparam logic [2:0] GROUP_BOTTOM_DEFAULT = 3'h1;
  localparam logic [2:0] GROUP_TOP_DEFAULT = 3'h4;
  localparam logic [21:0] PARAM_REGION_END = 22'h00_8000;
  localparam int MAIN_BLOCK_SHIFT = 15;
  localparam int PARAM_BLOCK_SHIFT = 12;
  localparam logic [7:0] PARAM_BLOCK_COUNT = 8'h08;

  // ==========================================================================
  // Register map, byte addresses
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_ADDR = 12'h004;
  localparam logic [11:0] REG_WDATA = 12'h008;
  localparam logic [11:0] REG_RDATA = 12'h00C;
  localparam logic [11:0] REG_STATUS = 12'h010;
  localparam logic [11:0] REG_GROUP = 12'h014;
  localparam logic [11:0] REG_BLOCK = 12'h018;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_DIE_BIT = 4;
  localparam int CTRL_FRESET_BIT = 8;

  // ==========================================================================
  // Encodings
  typedef enum logic [2:0] {
    OP_WRITE = 3'b000,
    OP_READ = 3'b001,
    OP_POLL = 3'b010,
    OP_GROUP_SET = 3'b011,
    OP_BUF_START = 3'b100
  } fsp_op_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ISSUE = 2'b01,
    SEQ_WAIT = 2'b10,
    SEQ_EVAL = 2'b11
  } fsp_seq_t;

  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_SETUP = 2'b01,
    CYC_STROBE = 2'b10,
    CYC_RECOVER = 2'b11
  } fsp_cyc_t;

endpackage : fsp_pkg

/* File: pkg/fsp_cycle_if.sv */
// One flash bus cycle request and its completion.
// Assumes the sequencer pulses req only while the cycle engine is idle.
interface fsp_cycle_if;
  logic req;
  logic wr;
  logic die;
  logic [fsp_pkg::ADDR_W-1:0] addr;
  logic [fsp_pkg::DATA_W-1:0] wdata;
  logic done;
  logic [fsp_pkg::DATA_W-1:0] rdata;

  modport sequencer (output req, output wr, output die, output addr, output wdata,
                     input done, input rdata);
  modport engine (input req, input wr, input die, input addr, input wdata,
                  output done, output rdata);
endinterface : fsp_cycle_if

/* File: hdl/fsp_bus_cycle.sv */
// Drives one asynchronous flash write or read cycle on the flash pins.
// Assumes flash data in is stable by the last strobe cycle.
module fsp_bus_cycle
  import fsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Request side
  fsp_cycle_if.engine cyc,
  // Flash pins
  output logic [fsp_pkg::ADDR_W-1:0] flashAddr,
  output logic [fsp_pkg::DATA_W-1:0] flashDqOut,
  output logic flashDqOe,
  input wire logic [fsp_pkg::DATA_W-1:0] flashDqIn,
  output logic flashCe1N,
  output logic flashCe2N,
  output logic flashWeN,
  output logic flashOeN
);

  fsp_cyc_t state;
  logic [7:0] count;
  logic isWrite;

  // ==========================================================================
  // Cycle sequencing
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state <= CYC_IDLE;
      count <= 8'h00;
      isWrite <= 1'b0;
      flashAddr <= '0;
      flashDqOut <= '0;
      flashDqOe <= 1'b0;
      flashCe1N <= 1'b1;
      flashCe2N <= 1'b1;
      flashWeN <= 1'b1;
      flashOeN <= 1'b1;
      cyc.done <= 1'b0;
      cyc.rdata <= '0;
    end
    else
    begin
      cyc.done <= 1'b0;
      case (state)
        CYC_IDLE:
        begin
          if (cyc.req)
          begin
            // Only the addressed die sees chip select low
            flashCe1N <= cyc.die;
            flashCe2N <= !cyc.die;
            flashAddr <= cyc.addr;
            flashDqOut <= cyc.wdata;
            flashDqOe <= cyc.wr;
            isWrite <= cyc.wr;
            count <= SETUP_CYC;
            state <= CYC_SETUP;
          end
        end
        CYC_SETUP:
        begin
          if (count <= 8'h01)
          begin
            flashWeN <= !isWrite;
            flashOeN <= isWrite;
            count <= STROBE_CYC;
            state <= CYC_STROBE;
          end
          else
            count <= count - 8'h01;
        end
        CYC_STROBE:
        begin
          if (count <= 8'h01)
          begin
            // Sample before output enable rises; device drives status here
            if (!isWrite)
              cyc.rdata <= flashDqIn;
            flashWeN <= 1'b1;
            flashOeN <= 1'b1;
            count <= RECOVER_CYC;
            state <= CYC_RECOVER;
          end
          else
            count <= count - 8'h01;
        end
        CYC_RECOVER:
        begin
          // Data held past the strobe so the write latches on its rising edge
          if (count <= 8'h01)
          begin
            flashCe1N <= 1'b1;
            flashCe2N <= 1'b1;
            flashDqOe <= 1'b0;
            cyc.done <= 1'b1;
            state <= CYC_IDLE;
          end
          else
            count <= count - 8'h01;
        end
        default:
          state <= CYC_IDLE;
      endcase
    end
  end

endmodule : fsp_bus_cycle

/* File: hdl/fsp_host.sv */
// Host controller for the flash status, extended status and grouping registers.
// Assumes an APB master on the register side and one flash with two dies on the pins.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
module fsp_host
  import fsp_pkg::*;
#(
  parameter int POLL_LIMIT = fsp_pkg::POLL_LIMIT_DEFAULT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash pins
  output logic [fsp_pkg::ADDR_W-1:0] flashAddr,
  output logic [fsp_pkg::DATA_W-1:0] flashDqOut,
  output logic flashDqOe,
  input wire logic [fsp_pkg::DATA_W-1:0] flashDqIn,
  output logic flashCe1N,
  output logic flashCe2N,
  output logic flashWeN,
  output logic flashOeN,
  output logic flashRstN,
  input wire logic flashReadyBusy
);

  fsp_cycle_if cyc ();

  fsp_seq_t state;
  fsp_op_t op;
  logic step;
  logic die;
  logic [ADDR_W-1:0] addrReg;
  logic [DATA_W-1:0] wdataReg;
  logic [DATA_W-1:0] rdataReg;
  logic [31:0] pollCount;
  logic [7:0] retryCount;
  logic busy;
  logic finish;
  logic doneFlag;
  logic timeoutFlag;
  logic refusedFlag;
  logic [7:0] statusFields;
  logic improper;
  logic bufAccept;
  logic [2:0] groupBottom;
  logic [2:0] groupTop;
  logic [2:0] groupRead;
  logic [2:0] groupSel;
  logic [2:0] partCount;
  logic [7:0] blockNum;
  logic apbWrite;
  logic apbSetup;
  logic startReq;
  logic doneClear;
  logic [31:0] readMux;
  logic readHit;
  logic [DATA_W-1:0] groupAddrLow;

  fsp_bus_cycle u_cycle (
    .clk(clk),
    .rstn(rstn),
    .cyc(cyc),
    .flashAddr(flashAddr),
    .flashDqOut(flashDqOut),
    .flashDqOe(flashDqOe),
    .flashDqIn(flashDqIn),
    .flashCe1N(flashCe1N),
    .flashCe2N(flashCe2N),
    .flashWeN(flashWeN),
    .flashOeN(flashOeN)
  );

  // ==========================================================================
  // APB decode
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pready && pwrite;
  assign startReq = apbWrite && (paddr == REG_CTRL) && pwdata[CTRL_START_BIT] && !busy;
  assign doneClear = apbWrite && (paddr == REG_STATUS) && pwdata[1];

  // New grouping value sits on the low address lines, reserved bits zero
  assign groupAddrLow = {5'h00, wdataReg[GROUP_LSB+2:GROUP_LSB], 8'h00};

  // Grouping code to partition count
  always_comb
  begin
    groupSel = die ? groupTop : groupBottom;
    case (groupSel)
      3'b000: partCount = 3'd1;
      3'b001, 3'b010, 3'b100: partCount = 3'd2;
      3'b011, 3'b101, 3'b110: partCount = 3'd3;
      3'b111: partCount = 3'd4;
      default: partCount = 3'd1;
    endcase
  end

  // Bottom die: eight small blocks, then main blocks up to the top
  always_comb
  begin
    if (addrReg < PARAM_REGION_END)
      blockNum = {5'h00, addrReg[PARAM_BLOCK_SHIFT+2:PARAM_BLOCK_SHIFT]};
    else
      blockNum = {1'b0, addrReg[ADDR_W-1:MAIN_BLOCK_SHIFT]} - 8'h01
                 + PARAM_BLOCK_COUNT;
  end

  always_comb
  begin
    readHit = 1'b1;
    case (paddr)
      REG_CTRL: readMux = {23'h00_0000, !flashRstN, 3'h0, die, op, 1'b0};
      REG_ADDR: readMux = {10'h000, addrReg};
      REG_WDATA: readMux = {16'h0000, wdataReg};
      REG_RDATA: readMux = {16'h0000, rdataReg};
      REG_STATUS: readMux = {8'h00, partCount, groupSel, bufAccept, improper,
                             statusFields, 4'h0, refusedFlag, timeoutFlag,
                             doneFlag, busy};
      REG_GROUP: readMux = {21'h00_0000, groupRead, 1'b0, groupTop, 1'b0, groupBottom};
      REG_BLOCK: readMux = {24'h00_0000, blockNum};
      default:
      begin
        readMux = 32'h0000_0000;
        readHit = 1'b0;
      end
    endcase
  end

  // Zero wait state: answer registered in the setup cycle
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= apbSetup;
      // Error stands only in the access cycle, like pready
      pslverr <= apbSetup && !readHit;
      if (apbSetup)
      begin
        prdata <= pwrite ? 32'h0000_0000 : readMux;
      end
    end
  end

  // ==========================================================================
  // Software registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      addrReg <= '0;
      wdataReg <= '0;
      flashRstN <= 1'b0;
    end
    else if (apbWrite && !busy)
    begin
      if (paddr == REG_ADDR)
        addrReg <= pwdata[ADDR_W-1:0];
      if (paddr == REG_WDATA)
        wdataReg <= pwdata[DATA_W-1:0];
      if (paddr == REG_CTRL)
        flashRstN <= !pwdata[CTRL_FRESET_BIT];
    end
  end

  // ==========================================================================
  // Operation sequencer
  assign busy = (state != SEQ_IDLE);

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state <= SEQ_IDLE;
      op <= OP_WRITE;
      step <= 1'b0;
      die <= 1'b0;
      pollCount <= 32'h0000_0000;
      retryCount <= 8'h00;
      finish <= 1'b0;
      cyc.req <= 1'b0;
      cyc.wr <= 1'b0;
      cyc.die <= 1'b0;
      cyc.addr <= '0;
      cyc.wdata <= '0;
    end
    else
    begin
      cyc.req <= 1'b0;
      finish <= 1'b0;
      case (state)
        SEQ_IDLE:
        begin
          if (startReq)
          begin
            op <= fsp_op_t'(pwdata[CTRL_OP_LSB+2:CTRL_OP_LSB]);
            die <= pwdata[CTRL_DIE_BIT];
            step <= 1'b0;
            pollCount <= 32'h0000_0000;
            retryCount <= 8'h00;
            state <= SEQ_ISSUE;
          end
        end
        SEQ_ISSUE:
        begin
          cyc.req <= 1'b1;
          cyc.die <= die;
          cyc.addr <= addrReg;
          cyc.wdata <= wdataReg;
          cyc.wr <= 1'b1;
          case (op)
            OP_READ, OP_POLL: cyc.wr <= 1'b0;
            OP_GROUP_SET:
            begin
              // Both cycles carry the same address
              cyc.addr <= {addrReg[ADDR_W-1:DATA_W], groupAddrLow};
              cyc.wdata <= step ? CMD_GROUP_CONFIRM : CMD_GROUP_SETUP;
            end
            OP_BUF_START:
            begin
              cyc.wr <= !step;
              cyc.wdata <= CMD_BUF_PROGRAM;
            end
            default: cyc.wr <= 1'b1;
          endcase
          state <= SEQ_WAIT;
        end
        SEQ_WAIT:
        begin
          if (cyc.done)
            state <= SEQ_EVAL;
        end
        SEQ_EVAL:
        begin
          state <= SEQ_IDLE;
          finish <= 1'b1;
          case (op)
            OP_POLL:
            begin
              // Completion needs both the ready bit and the ready pin
              if (!(cyc.rdata[SR_READY_BIT] && flashReadyBusy)
                  && (pollCount < 32'(POLL_LIMIT)))
              begin
                pollCount <= pollCount + 32'h0000_0001;
                finish <= 1'b0;
                state <= SEQ_ISSUE;
              end
            end
            OP_GROUP_SET:
            begin
              if (!step)
              begin
                step <= 1'b1;
                finish <= 1'b0;
                state <= SEQ_ISSUE;
              end
            end
            OP_BUF_START:
            begin
              if (!step)
              begin
                step <= 1'b1;
                finish <= 1'b0;
                state <= SEQ_ISSUE;
              end
              else if (!cyc.rdata[XSR_ACCEPT_BIT] && (retryCount < BUF_RETRY_LIMIT))
              begin
                // Not accepted: issue the buffer command again
                step <= 1'b0;
                retryCount <= retryCount + 8'h01;
                finish <= 1'b0;
                state <= SEQ_ISSUE;
              end
            end
            default: finish <= 1'b1;
          endcase
        end
        default:
          state <= SEQ_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Captured results and sticky flags
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rdataReg <= '0;
      doneFlag <= 1'b0;
      timeoutFlag <= 1'b0;
      refusedFlag <= 1'b0;
      statusFields <= 8'h00;
      improper <= 1'b0;
      bufAccept <= 1'b0;
      groupRead <= 3'h0;
    end
    else
    begin
      if (startReq)
      begin
        timeoutFlag <= 1'b0;
        refusedFlag <= 1'b0;
      end
      // A finish in the clearing cycle keeps the flag set
      if (finish)
        doneFlag <= 1'b1;
      else if (doneClear)
        doneFlag <= 1'b0;
      if (state == SEQ_EVAL && !cyc.wr)
      begin
        rdataReg <= cyc.rdata;
        groupRead <= cyc.rdata[GROUP_LSB+2:GROUP_LSB];
        if (op == OP_BUF_START)
        begin
          bufAccept <= cyc.rdata[XSR_ACCEPT_BIT];
          refusedFlag <= !cyc.rdata[XSR_ACCEPT_BIT] && (retryCount >= BUF_RETRY_LIMIT);
        end
        else if (cyc.rdata[SR_READY_BIT])
        begin
          // Fields 6..1 only mean something once ready; reserved bits dropped
          statusFields <= cyc.rdata[7:0] & SR_VALID_MASK[7:0];
          improper <= cyc.rdata[SR_ERASE_FAIL_BIT]
                      && cyc.rdata[SR_PROG_FAIL_BIT];
        end
        else
        begin
          statusFields <= 8'h00;
          improper <= 1'b0;
        end
        // Ready bit alone may hide an engine busy for another partition
        if (op == OP_POLL && pollCount >= 32'(POLL_LIMIT)
            && !(cyc.rdata[SR_READY_BIT] && flashReadyBusy))
          timeoutFlag <= 1'b1;
      end
    end
  end

  // Shadow of each die's grouping; device reset returns the defaults
  always_ff @(posedge clk)
  begin
    if (!rstn || !flashRstN)
    begin
      groupBottom <= GROUP_BOTTOM_DEFAULT;
      groupTop <= GROUP_TOP_DEFAULT;
    end
    else if (finish && op == OP_GROUP_SET)
    begin
      if (die)
        groupTop <= wdataReg[GROUP_LSB+2:GROUP_LSB];
      else
        groupBottom <= wdataReg[GROUP_LSB+2:GROUP_LSB];
    end
  end

endmodule : fsp_host

/* File: verification/fsp_host_properties.sv */
// Concurrent checks on the flash host top ports.
// Assumes one clock domain and the zero-wait APB slave of the host.
module fsp_host_properties
  import fsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Flash pins
  input wire logic [fsp_pkg::ADDR_W-1:0] flashAddr,
  input wire logic [fsp_pkg::DATA_W-1:0] flashDqOut,
  input wire logic flashDqOe,
  input wire logic flashCe1N,
  input wire logic flashCe2N,
  input wire logic flashWeN,
  input wire logic flashOeN,
  input wire logic flashRstN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // ==========================================================================
  // Register side
  property p_ready_after_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("pready missing after setup");
  property p_ready_cause;
    pready |-> $past(psel) && !$past(penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("pready without setup");
  property p_slverr_ready;
    pslverr |-> pready;
  endproperty
  a_slverr_ready: assert property (p_slverr_ready)
    else $error("pslverr outside access");
  property p_write_rdata;
    pready && pwrite |-> prdata == 32'h0000_0000;
  endproperty
  a_write_rdata: assert property (p_write_rdata)
    else $error("prdata not zero on write");
  property p_reset_state;
    $rose(rstn) |-> flashCe1N && flashCe2N && flashWeN && flashOeN && !flashDqOe
      && !flashRstN && !pready;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("pins not idle after reset");

  // ==========================================================================
  // Flash side
  property p_one_die;
    flashCe1N || flashCe2N;
  endproperty
  a_one_die: assert property (p_one_die)
    else $error("both dies selected");
  property p_strobe_die;
    !flashWeN || !flashOeN |-> flashCe1N != flashCe2N;
  endproperty
  a_strobe_die: assert property (p_strobe_die)
    else $error("strobe without one die");
  property p_read_release;
    !flashOeN |-> !flashDqOe && flashWeN;
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("host drives during read");
  property p_write_drive;
    !flashWeN |-> flashDqOe;
  endproperty
  a_write_drive: assert property (p_write_drive)
    else $error("write strobe without data");
  property p_write_hold;
    $fell(flashWeN) |-> ($stable(flashAddr) && $stable(flashDqOut) && !flashWeN) [*8];
  endproperty
  a_write_hold: assert property (p_write_hold)
    else $error("write cycle not held");
  property p_read_hold;
    $fell(flashOeN) |-> (!flashOeN && $stable(flashAddr)) [*8];
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read cycle not held");
  property p_reset_quiet;
    !flashRstN |-> flashCe1N && flashCe2N;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("flash cycle during flash reset");

  c_write: cover property ($fell(flashWeN));
  c_read: cover property ($fell(flashOeN));
  c_slverr: cover property (pslverr);
endmodule : fsp_host_properties

bind fsp_host fsp_host_properties props (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .flashAddr(flashAddr), .flashDqOut(flashDqOut),
  .flashDqOe(flashDqOe), .flashCe1N(flashCe1N), .flashCe2N(flashCe2N),
  .flashWeN(flashWeN), .flashOeN(flashOeN), .flashRstN(flashRstN));

/* File: verification/fsp_flash_model.sv */
// Behavioural two-die flash: status, extended status and plane grouping.
// Assumes the bench pulls the open-drain ready/busy pin up.
module fsp_flash_model
  import fsp_pkg::*;
(
  // Flash pins
  input wire logic [fsp_pkg::ADDR_W-1:0] flashAddr,
  input wire logic [fsp_pkg::DATA_W-1:0] flashDqOut,
  output logic [fsp_pkg::DATA_W-1:0] flashDqIn,
  input wire logic flashCe1N,
  input wire logic flashCe2N,
  input wire logic flashWeN,
  input wire logic flashOeN,
  input wire logic flashRstN,
  output logic busyPullEn,
  // Scenario controls
  input wire logic [15:0] statusWord,
  input wire logic [7:0] refuseCount
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] group [2];
  logic [21:0] setupAddr;
  logic setupSeen;
  logic badSeq;
  logic extMode;
  logic [7:0] refused;
  logic [15:0] lastDq;
  logic [15:0] readWord;
  logic dieSel;

  assign dieSel = flashRstN && (flashCe1N != flashCe2N);
  // Reserved top bit stands for another partition holding the shared engine
  assign busyPullEn = !statusWord[7] || statusWord[15];
  // Reserved bits come back set, so the host has to mask them
  // Supply and protect bits are the last checked result, not live levels
  assign readWord = extMode ? {8'hA5, refused >= refuseCount, 7'h2B}
    : statusWord | {10'h000, badSeq, badSeq, 4'h0};
  // Released bus shows the inverse of the last word, never a stale copy
  assign flashDqIn = (dieSel && !flashOeN) ? readWord : ~lastDq;

  always @(posedge flashWeN or negedge flashRstN)
  begin
    if (!flashRstN)
    begin
      group[0] <= 3'b001;
      group[1] <= 3'b100;
      setupSeen <= 1'b0;
      badSeq <= 1'b0;
      extMode <= 1'b0;
    end
    else if (dieSel)
    begin
      extMode <= flashDqOut[7:0] == 8'hE8 && !setupSeen;
      setupSeen <= flashDqOut[7:0] == 8'h60 && !setupSeen;
      setupAddr <= flashAddr;
      if (setupSeen)
      begin
        if (flashDqOut[7:0] == 8'h04 && flashAddr == setupAddr)
          group[flashCe1N] <= flashAddr[10:8];
        else
          badSeq <= 1'b1;
      end
    end
  end

  always @(posedge flashOeN or negedge flashRstN)
  begin
    if (!flashRstN)
    begin
      refused <= 8'h00;
      lastDq <= 16'h0000;
    end
    else if (dieSel)
    begin
      lastDq <= readWord;
      if (extMode && refused < refuseCount)
        refused <= refused + 8'h01;
    end
  end
endmodule : fsp_flash_model

/* File: verification/testbench.sv */
// Self-checking bench for the flash host: APB tasks and scripted scenarios.
// Assumes the behavioural flash on the pins and a zero-wait APB slave.
module testbench
  import fsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, flashDqOe, busyPullEn, flashReadyBusy;
  logic flashCe1N, flashCe2N, flashWeN, flashOeN, flashRstN;
  logic [21:0] flashAddr;
  logic [15:0] flashDqOut, flashDqIn;
  logic [15:0] statusWord = 16'h5A81;
  logic [7:0] refuseCount = 8'h00;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int total_checks = 0;
  logic [7:0] flags [8] = '{8'h81, 8'hC0, 8'hA0, 8'h90, 8'h88, 8'h84, 8'h82, 8'hB0};
  logic [21:0] blkAddr [4] = '{22'h3F_8000, 22'h00_8000, 22'h00_7FFF, 22'h00_0000};
  int blkNum [4] = '{134, 8, 7, 0};

  // Open-drain ready/busy with a pull-up
  assign flashReadyBusy = !busyPullEn;

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  fsp_host #(.POLL_LIMIT(8)) DUT (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flashAddr(flashAddr), .flashDqOut(flashDqOut),
    .flashDqOe(flashDqOe), .flashDqIn(flashDqIn), .flashCe1N(flashCe1N),
    .flashCe2N(flashCe2N), .flashWeN(flashWeN), .flashOeN(flashOeN),
    .flashRstN(flashRstN), .flashReadyBusy(flashReadyBusy));

  fsp_flash_model flashDev (.flashAddr(flashAddr), .flashDqOut(flashDqOut),
    .flashDqIn(flashDqIn), .flashCe1N(flashCe1N), .flashCe2N(flashCe2N),
    .flashWeN(flashWeN), .flashOeN(flashOeN), .flashRstN(flashRstN),
    .busyPullEn(busyPullEn), .statusWord(statusWord), .refuseCount(refuseCount));

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic timed_out;
    mismatches++;
    $display("BAD %0t: wait ran out", $time);
    test_done();
  endtask : timed_out

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      timed_out();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Bit 8 stays low so the flash is kept out of reset
  task automatic go(input logic [2:0] op, input logic die);
    apb(1'b1, REG_CTRL, {27'h0, die, op, 1'b1});
  endtask : go

  task automatic wait_done;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 1000);
    if (n >= 1000)
      timed_out();
    apb(1'b1, REG_STATUS, 32'h0000_0002);
  endtask : wait_done

  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, REG_GROUP, 32'h0);
    check(rd & 32'h77, 32'h0000_0041);
    apb(1'b0, 12'h0FC, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b1, REG_ADDR, 32'h0);
    foreach (flags[i])
    begin
      statusWord <= {8'h5A, flags[i]};
      go(OP_POLL, 1'b0);
      wait_done();
      apb(1'b0, REG_STATUS, 32'h0);
      check(32'(rd[16:8]), {23'h0, flags[i][5] & flags[i][4], flags[i] & 8'hFE});
    end
    statusWord <= 16'h0000;
    go(OP_POLL, 1'b0);
    repeat (60) @(posedge clk);
    statusWord <= 16'h5A84;
    wait_done();
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd & 32'h0000_FF04, 32'h0000_8400);
    statusWord <= 16'h0000;
    go(OP_POLL, 1'b0);
    wait_done();
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd & 32'h0000_FF04, 32'h0000_0004);
    statusWord <= 16'h8080;
    go(OP_POLL, 1'b0);
    wait_done();
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd & 32'h0000_FF04, 32'h0000_8004);
    statusWord <= 16'h5A81;
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, REG_WDATA, 32'(c) << 8);
      go(OP_GROUP_SET, 1'b0);
      wait_done();
      check(32'(flashDev.group[0]), 32'(c));
      apb(1'b0, REG_STATUS, 32'h0);
      check(32'(rd[23:18]), 32'(($countones(c) + 1) * 8 + c));
    end
    apb(1'b1, REG_WDATA, 32'h0000_0300);
    go(OP_GROUP_SET, 1'b1);
    wait_done();
    apb(1'b0, REG_GROUP, 32'h0);
    check(rd & 32'h77, 32'h0000_0037);
    go(OP_READ, 1'b0);
    wait_done();
    apb(1'b0, REG_RDATA, 32'h0);
    check(rd, 32'h0000_5A81);
    apb(1'b1, REG_WDATA, 32'h0000_0060);
    go(OP_WRITE, 1'b0);
    wait_done();
    apb(1'b1, REG_WDATA, 32'h0000_00FF);
    go(OP_WRITE, 1'b0);
    wait_done();
    go(OP_POLL, 1'b0);
    wait_done();
    apb(1'b0, REG_STATUS, 32'h0);
    check(32'(rd[16:8]), 32'h0000_01B0);
    apb(1'b1, REG_CTRL, 32'h0000_0100);
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b0, REG_GROUP, 32'h0);
    check(rd & 32'h77, 32'h0000_0041);
    apb(1'b1, REG_ADDR, 32'h0000_1000);
    refuseCount <= 8'd2;
    go(OP_BUF_START, 1'b0);
    wait_done();
    apb(1'b0, REG_STATUS, 32'h0);
    check({30'h0, rd[17], rd[3]}, 32'h2);
    refuseCount <= 8'd20;
    go(OP_BUF_START, 1'b0);
    wait_done();
    apb(1'b0, REG_STATUS, 32'h0);
    check({30'h0, rd[17], rd[3]}, 32'h1);
    foreach (blkAddr[i])
    begin
      apb(1'b1, REG_ADDR, {10'h0, blkAddr[i]});
      apb(1'b0, REG_BLOCK, 32'h0);
      check(rd, 32'(blkNum[i]));
    end
    test_done();
  end
endmodule : testbench
